// ==== logic/flash_guard_pkg.sv ====
// shared constants and types for the flash block erase and protection logic
package flash_guard_pkg;

  localparam int unsigned FLASH_KB   = 64;
  localparam int unsigned BLOCK_KB   = 1;
  localparam int unsigned REGION_KB  = 2;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned WORD_W     = 32;

  localparam int unsigned WORDS        = FLASH_KB * 1024 / WORD_BYTES;
  localparam int unsigned BLOCK_WORDS  = BLOCK_KB * 1024 / WORD_BYTES;
  localparam int unsigned NUM_BLOCKS   = FLASH_KB / BLOCK_KB;
  localparam int unsigned NUM_REGIONS  = FLASH_KB / REGION_KB;
  localparam int unsigned ADDR_W       = $clog2(WORDS);
  localparam int unsigned PTR_W        = $clog2(BLOCK_WORDS);
  localparam int unsigned BLK_W        = $clog2(NUM_BLOCKS);
  localparam int unsigned REGION_W     = $clog2(NUM_REGIONS);
  localparam int unsigned ERASE_CYCLES = BLOCK_WORDS;

  localparam logic [WORD_W-1:0] ERASED_WORD = 32'hFFFF_FFFF;
  localparam logic [WORD_W-1:0] DENIED_WORD = 32'h0000_0000;
  localparam logic [PTR_W-1:0]  PTR_LAST    = 8'hFF;

  typedef enum logic [1:0] {
    SRC_FETCH = 2'b00,
    SRC_DATA  = 2'b01,
    SRC_DEBUG = 2'b10
  } src_t;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_ERASE = 1'b1
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t         st;
    logic [PTR_W-1:0]   ptr;
    logic [BLK_W-1:0]   blk;
    logic               busy;
    logic               rd_valid;
    logic               rd_denied;
    logic [WORD_W-1:0]  rd_data;
    logic               done;
    logic               refused;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    st:        ST_IDLE,
    ptr:       8'h00,
    blk:       6'h00,
    busy:      1'b0,
    rd_valid:  1'b0,
    rd_denied: 1'b0,
    rd_data:   32'h0000_0000,
    done:      1'b0,
    refused:   1'b0
  };

endpackage

// ==== logic/region_guard.sv ====
// protection decision for one access against the per-region attributes
`timescale 1ns/10ps
`default_nettype none

module region_guard (
  input  wire logic [flash_guard_pkg::REGION_W-1:0]    region_i,
  input  wire logic                                     modify_i,
  input  wire flash_guard_pkg::src_t                   src_i,
  input  wire logic [flash_guard_pkg::NUM_REGIONS-1:0] ro_i,
  input  wire logic [flash_guard_pkg::NUM_REGIONS-1:0] xo_i,
  output logic                                          allow_o
);

  logic ro_hit;
  logic xo_hit;

  assign ro_hit = ro_i[region_i];
  assign xo_hit = xo_i[region_i];

  always_comb begin
    if (modify_i) begin
      allow_o = !ro_hit && !xo_hit;
    end else begin
      // execute-only regions feed the fetch path alone
      allow_o = !xo_hit || (src_i == flash_guard_pkg::SRC_FETCH);
    end
  end

endmodule
`default_nettype wire

// ==== logic/flash_block_erase_protect.sv ====
// flash array with block erase and per-region read-only / execute-only guard
//
// Behaviour
// - 64 KB flash in 1-KB blocks, each erasable alone without touching others.
// - a completed block erase leaves every word of the block all ones.
// - protection applies per 2-KB region, two adjacent blocks sharing one setting.
// - read-only regions refuse every erase and program request.
// - execute-only regions refuse every erase and program request too.
// - execute-only regions serve instruction fetches, deny data and debugger reads.
// - a permitted read completes in one clock cycle.
`timescale 1ns/10ps
`default_nettype none

module flash_block_erase_protect (
  input  wire logic                                     clk_i,
  input  wire logic                                     reset_i,
  input  wire logic [flash_guard_pkg::NUM_REGIONS-1:0] prot_ro_i,
  input  wire logic [flash_guard_pkg::NUM_REGIONS-1:0] prot_xo_i,
  input  wire logic                                     rd_req_i,
  input  wire logic [flash_guard_pkg::ADDR_W-1:0]      rd_addr_i,
  input  wire flash_guard_pkg::src_t                   rd_src_i,
  input  wire logic                                     prog_req_i,
  input  wire logic [flash_guard_pkg::ADDR_W-1:0]      prog_addr_i,
  input  wire logic [flash_guard_pkg::WORD_W-1:0]      prog_data_i,
  input  wire logic                                     erase_req_i,
  input  wire logic [flash_guard_pkg::BLK_W-1:0]       erase_blk_i,
  output logic                                          rd_valid_o,
  output logic                                          rd_denied_o,
  output logic [flash_guard_pkg::WORD_W-1:0]           rd_data_o,
  output logic                                          busy_o,
  output logic                                          done_o,
  output logic                                          refused_o
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  // no reset on the array: flash contents survive reset
  logic [flash_guard_pkg::WORD_W-1:0] mem [0:flash_guard_pkg::WORDS-1];

  logic                                 we;
  logic [flash_guard_pkg::ADDR_W-1:0]  waddr;
  logic [flash_guard_pkg::WORD_W-1:0]  wdata;
  logic [flash_guard_pkg::WORD_W-1:0]  rd_word;
  logic [flash_guard_pkg::WORD_W-1:0]  prog_old;

  assign rd_word  = mem[rd_addr_i];
  assign prog_old = mem[prog_addr_i];

  always_ff @(posedge clk_i) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection lookup

  logic                                   rd_ok;
  logic                                   mod_ok;
  logic [flash_guard_pkg::REGION_W-1:0]  rd_region;
  logic [flash_guard_pkg::REGION_W-1:0]  mod_region;

  // region index drops the lowest block bit, pairing adjacent blocks
  assign rd_region  = rd_addr_i[flash_guard_pkg::ADDR_W-1:flash_guard_pkg::ADDR_W-flash_guard_pkg::REGION_W];
  assign mod_region = erase_req_i ? erase_blk_i[flash_guard_pkg::BLK_W-1:1]
                    : prog_addr_i[flash_guard_pkg::ADDR_W-1:flash_guard_pkg::ADDR_W-flash_guard_pkg::REGION_W];

  region_guard u_rd_guard (
    .region_i (rd_region),
    .modify_i (1'b0),
    .src_i    (rd_src_i),
    .ro_i     (prot_ro_i),
    .xo_i     (prot_xo_i),
    .allow_o  (rd_ok)
  );

  region_guard u_mod_guard (
    .region_i (mod_region),
    .modify_i (1'b1),
    .src_i    (flash_guard_pkg::SRC_DATA),
    .ro_i     (prot_ro_i),
    .xo_i     (prot_xo_i),
    .allow_o  (mod_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control

  flash_guard_pkg::ctl_t cur;
  flash_guard_pkg::ctl_t next_cur;

  always_comb begin
    next_cur         = cur;
    next_cur.rd_valid = 1'b0;
    next_cur.done    = 1'b0;
    next_cur.refused = 1'b0;
    we               = 1'b0;
    waddr            = prog_addr_i;
    wdata            = prog_old & prog_data_i;

    if (rd_req_i) begin
      next_cur.rd_valid = 1'b1;
      if (rd_ok) begin
        next_cur.rd_data   = rd_word;
        next_cur.rd_denied = 1'b0;
      end else begin
        next_cur.rd_data   = flash_guard_pkg::DENIED_WORD;
        next_cur.rd_denied = 1'b1;
      end
    end

    unique case (cur.st)
      flash_guard_pkg::ST_IDLE: begin
        // erase wins when both arrive; the program is then refused
        if (erase_req_i) begin
          if (mod_ok) begin
            next_cur.st   = flash_guard_pkg::ST_ERASE;
            next_cur.ptr  = '0;
            next_cur.blk  = erase_blk_i;
            next_cur.busy = 1'b1;
          end else begin
            next_cur.refused = 1'b1;
          end
          if (prog_req_i) begin
            next_cur.refused = 1'b1;
          end
        end else if (prog_req_i) begin
          if (mod_ok) begin
            // programming only clears bits, as a flash cell does
            we            = 1'b1;
            next_cur.done = 1'b1;
          end else begin
            next_cur.refused = 1'b1;
          end
        end
      end
      flash_guard_pkg::ST_ERASE: begin
        we           = 1'b1;
        waddr        = {cur.blk, cur.ptr};
        wdata        = flash_guard_pkg::ERASED_WORD;
        next_cur.ptr = cur.ptr + 1'b1;
        if (cur.ptr == flash_guard_pkg::PTR_LAST) begin
          next_cur.st   = flash_guard_pkg::ST_IDLE;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
        end
        // one erase or program at a time; such a request during an erase is dropped
        if (erase_req_i || prog_req_i) begin
          next_cur.refused = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= flash_guard_pkg::CTL_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_valid_o  = cur.rd_valid;
  assign rd_denied_o = cur.rd_denied;
  assign rd_data_o   = cur.rd_data;
  assign busy_o      = cur.busy;
  assign done_o      = cur.done;
  assign refused_o   = cur.refused;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [flash_guard_pkg::REGION_W-1:0] w_region;
  assign w_region = waddr[flash_guard_pkg::ADDR_W-1:flash_guard_pkg::ADDR_W-flash_guard_pkg::REGION_W];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_erase_length: assert property (
    $rose(cur.busy) |-> ##256 (!cur.busy && cur.done))
    else $error("erase did not finish after one block of words");

  chk_erase_ones: assert property (
    cur.st == flash_guard_pkg::ST_ERASE |->
      we && wdata == flash_guard_pkg::ERASED_WORD && waddr[13:8] == cur.blk)
    else $error("erase wrote something other than all ones to its block");

  chk_ro_no_write: assert property (
    we |-> !prot_ro_i[w_region])
    else $error("write landed in a read-only region");

  chk_xo_no_write: assert property (
    we |-> !prot_xo_i[w_region])
    else $error("write landed in an execute-only region");

  chk_xo_read_deny: assert property (
    rd_req_i && prot_xo_i[rd_region] && rd_src_i != flash_guard_pkg::SRC_FETCH |=>
      rd_valid_o && rd_denied_o && rd_data_o == flash_guard_pkg::DENIED_WORD)
    else $error("protected contents returned to a data or debug read");

  chk_fetch_served: assert property (
    rd_req_i && rd_src_i == flash_guard_pkg::SRC_FETCH |=> rd_valid_o && !rd_denied_o)
    else $error("instruction fetch was denied");

  chk_read_data: assert property (
    rd_req_i && rd_ok |=> rd_valid_o && rd_data_o == $past(rd_word))
    else $error("permitted read did not return stored word next cycle");

  chk_refuse_idle: assert property (
    erase_req_i && !mod_ok && cur.st == flash_guard_pkg::ST_IDLE |=>
      refused_o && !busy_o && !done_o)
    else $error("protected erase was not refused");

  cov_erase_full: cover property ($rose(cur.busy) ##256 cur.done);
  cov_xo_fetch:   cover property (rd_req_i && prot_xo_i[rd_region] &&
                                  rd_src_i == flash_guard_pkg::SRC_FETCH);
  cov_ro_refuse:  cover property (prog_req_i && prot_ro_i[mod_region] ##1 refused_o);

endmodule
`default_nettype wire

// ==== verif/read_master.sv ====
// requester model for the fetch, data and debugger read port
`timescale 1ns/10ps
`default_nettype none

module read_master (
  input  wire logic                           clk_i,
  output logic                                req_o,
  output logic [flash_guard_pkg::ADDR_W-1:0]  addr_o,
  output flash_guard_pkg::src_t               src_o
);
  initial begin
    req_o = 1'b0;
    addr_o = '0;
    src_o = flash_guard_pkg::SRC_FETCH;
  end

  ////////////////////////////////////////////////////////////////
  task automatic read_word(input logic [13:0] a, input flash_guard_pkg::src_t s);
    @(negedge clk_i);
    req_o = 1'b1;
    addr_o = a;
    src_o = s;
    @(negedge clk_i);
    req_o = 1'b0;
    // released lines flip so a stale address never looks valid
    addr_o = ~a;
    src_o = flash_guard_pkg::src_t'(~s);
  endtask
endmodule

`default_nettype wire

// ==== verif/flash_block_erase_protect_tb_top.sv ====
// random and corner tests of flash block erase and region protection
`timescale 1ns/10ps
`default_nettype none

module flash_block_erase_protect_tb_top;
  logic                                     clk = 1'b0;
  logic                                     reset = 1'b1;
  logic [31:0]                              ro = '0;
  logic [31:0]                              xo = '0;
  logic                                     rd_req;
  logic [13:0]                              rd_addr;
  flash_guard_pkg::src_t                    rd_src;
  logic                                     prog_req = 1'b0;
  logic [13:0]                              prog_addr = '0;
  logic [31:0]                              prog_data = '0;
  logic                                     erase_req = 1'b0;
  logic [5:0]                               erase_blk = '0;
  logic                                     rd_valid;
  logic                                     rd_denied;
  logic [31:0]                              rd_data;
  logic                                     busy;
  logic                                     done;
  logic                                     refused;
  logic [31:0]                              mem_m [flash_guard_pkg::WORDS];
  int                                       num_errors = 0;
  int                                       total_checks = 0;
  int                                       seed = 8195;
  logic [13:0]                              a;
  logic [4:0]                               r;

  always #20 clk = ~clk;

  read_master host (.clk_i(clk), .req_o(rd_req), .addr_o(rd_addr), .src_o(rd_src));

  flash_block_erase_protect dut (
    .clk_i(clk), .reset_i(reset), .prot_ro_i(ro), .prot_xo_i(xo),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_src_i(rd_src),
    .prog_req_i(prog_req), .prog_addr_i(prog_addr), .prog_data_i(prog_data),
    .erase_req_i(erase_req), .erase_blk_i(erase_blk),
    .rd_valid_o(rd_valid), .rd_denied_o(rd_denied), .rd_data_o(rd_data),
    .busy_o(busy), .done_o(done), .refused_o(refused));

  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask

  function automatic logic hidden(input logic [13:0] ad, input flash_guard_pkg::src_t s);
    return xo[ad[13:9]] && (s != flash_guard_pkg::SRC_FETCH);
  endfunction

  task automatic rd_chk(input logic [13:0] ad, input flash_guard_pkg::src_t s);
    host.read_word(ad, s);
    cmp_flag(rd_valid, 1'b1);
    cmp_flag(rd_denied, hidden(ad, s));
    cmp_word(rd_data, hidden(ad, s) ? 32'h0000_0000 : mem_m[ad]);
    // valid is a single-cycle pulse, not a level
    @(negedge clk);
    cmp_flag(rd_valid, 1'b0);
  endtask

  task automatic prog(input logic [13:0] ad, input logic [31:0] d, input logic ok);
    @(negedge clk);
    prog_req = 1'b1;
    prog_addr = ad;
    prog_data = d;
    @(negedge clk);
    prog_req = 1'b0;
    prog_data = ~d;
    cmp_flag(done, ok);
    cmp_flag(refused, !ok);
    if (ok) mem_m[ad] = mem_m[ad] & d;
  endtask

  task automatic erase(input logic [5:0] b, input logic ok);
    int n;
    @(negedge clk);
    erase_req = 1'b1;
    erase_blk = b;
    @(negedge clk);
    erase_req = 1'b0;
    cmp_flag(busy, ok);
    cmp_flag(refused, !ok);
    n = 0;
    // a program poked mid-erase must bounce, not queue
    while (ok && !done && n < 300) begin
      @(negedge clk);
      n++;
      if (n == 6) cmp_flag(refused, 1'b1);
      prog_req = (n == 5);
      prog_addr = {b, 8'h00};
    end
    if (ok) begin
      cmp_word(n, flash_guard_pkg::ERASE_CYCLES);
      for (int i = 0; i < 256; i++) mem_m[{b, i[7:0]}] = flash_guard_pkg::ERASED_WORD;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    // array powers up unknown, so every block is erased first
    for (int b = 0; b < 64; b++) erase(b[5:0], 1'b1);
    for (int i = 0; i < 40; i++) begin
      a = 14'($random(seed));
      rd_chk(a, flash_guard_pkg::SRC_FETCH);
      prog(a, $random(seed), 1'b1);
      rd_chk(a, flash_guard_pkg::src_t'(i % 3));
    end
    r = 5'($random(seed));
    if (r == 5'd31) r = 5'd30;
    a = {r, 9'($random(seed))};
    // a cleared word shows whether a refused erase touched the block
    prog({r, 9'h1ff}, 32'h0000_0000, 1'b1);
    ro[r] = 1'b1;
    erase({r, 1'b0}, 1'b0);
    erase({r, 1'b1}, 1'b0);
    prog(a, 32'h0000_0000, 1'b0);
    rd_chk(a, flash_guard_pkg::SRC_DEBUG);
    prog({5'(r + 1), 9'h100}, 32'h0000_0000, 1'b1);
    erase({5'(r + 1), 1'b0}, 1'b1);
    rd_chk({5'(r + 1), 9'h100}, flash_guard_pkg::SRC_FETCH);
    rd_chk({5'(r + 1), 9'h0ff}, flash_guard_pkg::SRC_DATA);
    rd_chk({r, 9'h1ff}, flash_guard_pkg::SRC_DATA);
    ro = '0;
    xo[r] = 1'b1;
    erase({r, 1'b1}, 1'b0);
    prog(a, 32'h0000_0000, 1'b0);
    for (int s = 0; s < 4; s++) rd_chk(a, flash_guard_pkg::src_t'(s));
    // erase and program in one cycle: erase goes ahead, program bounces
    @(negedge clk);
    erase_req = 1'b1;
    erase_blk = {5'(r + 1), 1'b1};
    prog_req = 1'b1;
    prog_addr = {5'(r + 1), 9'h100};
    prog_data = 32'h0000_0000;
    @(negedge clk);
    erase_req = 1'b0;
    prog_req = 1'b0;
    cmp_flag(busy, 1'b1);
    cmp_flag(refused, 1'b1);
    repeat (256) @(negedge clk);
    cmp_flag(done, 1'b1);
    for (int i = 0; i < 256; i++) mem_m[{5'(r + 1), 1'b1, i[7:0]}] = flash_guard_pkg::ERASED_WORD;
    rd_chk({5'(r + 1), 9'h100}, flash_guard_pkg::SRC_FETCH);
    end_sim;
  end

  initial begin
    #(40 * 40000);
    num_errors++;
    end_sim;
  end
endmodule

`default_nettype wire
